// *** verification/fp_store_decode_check_test.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "fsd_consts.svh"
module fp_store_decode_check_test
	import fsd_pkg::*;
;
	logic i_clk, i_rst, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic i_insn_valid, o_insn_ready, i_float_operation_busy, o_mem_valid, i_mem_ready;
	logic [31:0] i_insn;
	logic [63:0] i_src_one, i_src_two, i_fp_data, i_state_reg;
	logic o_trap_valid, err;
	logic [2:0] o_trap_type;
	logic [3:0] mem_wait;
	fsd_mem_req_t o_mem_req, r_req;
	fsd_trap_t o_trap_code, r_code;
	int errors, checked;

	fsd_store_check DUT (.i_clk(i_clk), .i_rst(i_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.i_insn_valid(i_insn_valid), .o_insn_ready(o_insn_ready),
		.i_insn(i_insn), .i_src_one(i_src_one), .i_src_two(i_src_two),
		.i_fp_data(i_fp_data), .i_state_reg(i_state_reg),
		.i_float_operation_busy(i_float_operation_busy), .o_mem_valid(o_mem_valid),
		.i_mem_ready(i_mem_ready), .o_mem_req(o_mem_req),
		.o_trap_valid(o_trap_valid), .o_trap_code(o_trap_code),
		.o_trap_type(o_trap_type));
	fsd_mem_model MEM (.i_clk(i_clk), .i_rst(i_rst),
		.i_mem_valid(o_mem_valid), .i_wait(mem_wait),
		.o_mem_ready(i_mem_ready));

	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end

	task automatic give_verdict();
		if (errors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : give_verdict

	task automatic chk(string nm, logic [63:0] exp, logic [63:0] got);
		checked++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", nm, exp, got);
			errors++;
		end
	endtask : chk

	task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
		@(posedge i_clk);
		psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge i_clk);
		penable <= 1'b1;
		do begin
			@(posedge i_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask : apb

	task automatic send(logic [5:0] op3, logic [4:0] fr, logic i,
		logic [12:0] lo, logic [63:0] s1, logic [63:0] s2);
		@(posedge i_clk);
		i_insn <= {2'b11, fr, op3, 5'h01, i, lo};
		i_src_one <= s1; i_src_two <= s2; i_insn_valid <= 1'b1;
		do begin
			@(posedge i_clk);
		end while (o_insn_ready !== 1'b1);
		i_insn_valid <= 1'b0;
	endtask : send

	task automatic result();
		r_code = FSD_T_NONE;
		forever begin
			@(negedge i_clk);
			if (o_trap_valid === 1'b1) begin
				r_code = o_trap_code;
				break;
			end
			if (o_mem_valid === 1'b1 && i_mem_ready === 1'b1) begin
				r_req = o_mem_req;
				break;
			end
		end
		@(posedge i_clk);
	endtask : result

	task automatic try(logic [5:0] op3, logic i, logic [12:0] lo,
		logic [63:0] s1, logic [63:0] s2, fsd_trap_t exp);
		send(op3, 5'h05, i, lo, s1, s2);
		result();
		chk("trap code", 64'(exp), 64'(r_code));
	endtask : try

	task automatic t_regs();
		apb(1'b0, `FSD_OFF_CTRL, 32'h0);
		chk("ctrl reset", 64'h8, 64'(rd));
		apb(1'b0, `FSD_OFF_SPACE, 32'h0);
		chk("space reset", 64'h80, 64'(rd));
		apb(1'b0, 12'h040, 32'h0);
		chk("unmapped err", 64'h1, 64'(err));
	endtask : t_regs

	task automatic t_plain();
		apb(1'b1, `FSD_OFF_CTRL, 32'hf);
		try(6'h24, 1'b1, 13'h0010, 64'h1000, 64'h0, FSD_T_NONE);
		chk("single addr", 64'h1010, r_req.addr);
		chk("single data", 64'(i_fp_data[31:0]), 64'(r_req.data[31:0]));
		chk("single reg", 64'h5, 64'(r_req.freg));
		mem_wait <= 4'h3;
		try(6'h27, 1'b1, 13'h1ff8, 64'h2010, 64'h0, FSD_T_NONE);
		chk("double kind", 64'(FSD_K_DOUBLE), 64'(r_req.kind));
		chk("double data", i_fp_data, r_req.data);
		chk("double addr", 64'h2008, r_req.addr);
		mem_wait <= 4'h0;
		try(6'h27, 1'b0, 13'h0001, 64'h2000, 64'h8, FSD_T_NONE);
		chk("sum addr", 64'h2008, r_req.addr);
		try(6'h27, 1'b1, 13'h0004, 64'h2000, 64'h0,
			FSD_T_DOUBLE_MISALIGN);
		try(6'h24, 1'b1, 13'h0002, 64'h1000, 64'h0, FSD_T_MISALIGN);
		try(6'h26, 1'b1, 13'h0000, 64'h1000, 64'h0,
			FSD_T_BAD_ENCODING);
		try(6'h24, 1'b0, 13'h0020, 64'h1000, 64'h0,
			FSD_T_BAD_ENCODING);
		send(6'h25, 5'h02, 1'b1, 13'h0, 64'h3000, 64'h0);
		result();
		chk("reserved", 64'(FSD_T_BAD_ENCODING), 64'(r_code));
	endtask : t_plain

	task automatic t_off();
		logic [3:0] cv [3] = '{4'h9, 4'ha, 4'h7};
		foreach (cv[k]) begin
			apb(1'b1, `FSD_OFF_CTRL, 32'(cv[k]));
			try(6'h24, 1'b1, 13'h0, 64'h1000, 64'h0, FSD_T_FLOAT_OFF);
		end
		try(6'h24, 1'b1, 13'h2, 64'h1000, 64'h0, FSD_T_FLOAT_OFF);
		try(6'h27, 1'b0, 13'h40, 64'h1000, 64'h0,
			FSD_T_BAD_ENCODING);
	endtask : t_off

	task automatic t_alt();
		apb(1'b1, `FSD_OFF_CTRL, 32'hb);
		try(6'h34, 1'b0, {8'h80, 5'h0}, 64'h100, 64'h0, FSD_T_NONE);
		chk("inline space", 64'h80, 64'(r_req.space));
		apb(1'b1, `FSD_OFF_SPACE, 32'h04);
		try(6'h34, 1'b1, 13'h0, 64'h100, 64'h0,
			FSD_T_SUPERVISOR_ONLY);
		apb(1'b1, `FSD_OFF_CTRL, 32'hf);
		try(6'h34, 1'b1, 13'h0, 64'h100, 64'h0, FSD_T_NONE);
		chk("reg space", 64'h04, 64'(r_req.space));
		try(6'h34, 1'b0, {8'h30, 5'h0}, 64'h100, 64'h0,
			FSD_T_SUPERVISOR_ONLY);
		try(6'h37, 1'b0, {8'h7f, 5'h0}, 64'h100, 64'h0,
			FSD_T_SUPERVISOR_ONLY);
		try(6'h34, 1'b0, {8'h20, 5'h0}, 64'h100, 64'h0,
			FSD_T_SPACE_REJECT);
		try(6'h36, 1'b0, {8'h80, 5'h0}, 64'h100, 64'h0,
			FSD_T_BAD_ENCODING);
		try(6'h34, 1'b0, {8'h80, 5'h0}, 64'h102, 64'h0, FSD_T_MISALIGN);
		try(6'h37, 1'b0, {8'h80, 5'h0}, 64'h104, 64'h0,
			FSD_T_DOUBLE_MISALIGN);
		try(6'h37, 1'b0, {8'hf0, 5'h0}, 64'h140, 64'h0, FSD_T_NONE);
		chk("block kind", 64'(FSD_K_BLOCK), 64'(r_req.kind));
		try(6'h37, 1'b0, {8'hc0, 5'h0}, 64'h100, 64'h0, FSD_T_NONE);
		chk("masked kind", 64'(FSD_K_MASKED), 64'(r_req.kind));
	endtask : t_alt

	task automatic t_state();
		apb(1'b1, `FSD_OFF_TRAPTYPE, 32'h5);
		send(6'h25, 5'h01, 1'b1, 13'h4, 64'h3000, 64'h0);
		result();
		chk("state align", 64'(FSD_T_MISALIGN), 64'(r_code));
		apb(1'b0, `FSD_OFF_TRAPTYPE, 32'h0);
		chk("type kept", 64'h5, 64'(rd[2:0]));
		apb(1'b0, `FSD_OFF_STATUS, 32'h0);
		chk("status", 64'(FSD_T_MISALIGN), 64'(rd));
		i_float_operation_busy <= 1'b1;
		send(6'h25, 5'h01, 1'b1, 13'h8, 64'h3000, 64'h0);
		repeat (6) begin
			@(negedge i_clk);
			chk("wait busy", 64'h0, 64'(o_mem_valid));
		end
		@(posedge i_clk);
		i_float_operation_busy <= 1'b0;
		result();
		chk("state data", i_state_reg, r_req.data);
		chk("state kind", 64'(FSD_K_STATE), 64'(r_req.kind));
		apb(1'b0, `FSD_OFF_TRAPTYPE, 32'h0);
		chk("type clear", 64'h0, 64'(rd[2:0]));
		chk("type port", 64'h0, 64'(o_trap_type));
	endtask : t_state

	initial begin
		errors = 0; checked = 0;
		i_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 12'h000; pwdata = 32'h0; i_insn_valid = 1'b0;
		i_insn = 32'h0; i_src_one = 64'h0; i_src_two = 64'h0;
		i_fp_data = 64'h1234_5678_9abc_def0;
		i_state_reg = 64'h0fed_cba9_8765_4321;
		i_float_operation_busy = 1'b0; mem_wait = 4'h0;
		repeat (16) @(posedge i_clk);
		i_rst <= 1'b0;
		t_regs();
		t_plain();
		t_off();
		t_alt();
		t_state();
		give_verdict();
	end

	// The whole sequence needs a few hundred cycles at most.
	initial begin
		#(20000 * 100);
		$display("wrong value run time expected done seen timeout");
		errors++;
		give_verdict();
	end
endmodule : fp_store_decode_check_test
`default_nettype wire

// *** verification/fsd_mem_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module fsd_mem_model (
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic       i_mem_valid,
	input  wire logic [3:0] i_wait,
	output var  logic       o_mem_ready
);
	logic [3:0] cnt_r;

	// Each request is taken whole, a double as one 64-bit write.
	// Trapped stores never come here; software would emulate them.
	// The ready pulse lasts one cycle, so a stuck valid is seen at once.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_r       <= 4'h0;
			o_mem_ready <= 1'b0;
		end else if (i_mem_valid && !o_mem_ready) begin
			cnt_r       <= (cnt_r == i_wait) ? 4'h0 : cnt_r + 4'h1;
			o_mem_ready <= (cnt_r == i_wait);
		end else begin
			cnt_r       <= 4'h0;
			o_mem_ready <= 1'b0;
		end
	end
endmodule : fsd_mem_model
`default_nettype wire

// *** verilog/fsd_consts.svh ***
`ifndef FSD_CONSTS_SVH
`define FSD_CONSTS_SVH

`define FSD_OFF_CTRL      12'h000
`define FSD_OFF_SPACE     12'h004
`define FSD_OFF_STATUS    12'h008
`define FSD_OFF_TRAPTYPE  12'h00c

`define FSD_CTRL_FPEN     0
`define FSD_CTRL_STEN     1
`define FSD_CTRL_SUPER    2
`define FSD_CTRL_PRESENT  3
`define FSD_CTRL_RST      4'h8
`define FSD_SPACE_RST     8'h80
`define FSD_TT_RST        3'h0

`define FSD_OP_MEM        2'h3
`define FSD_OP3_SINGLE    6'h24
`define FSD_OP3_DOUBLE    6'h27
`define FSD_OP3_QUAD      6'h26
`define FSD_OP3_STATE     6'h25
`define FSD_OP3_SINGLE_A  6'h34
`define FSD_OP3_DOUBLE_A  6'h37
`define FSD_OP3_QUAD_A    6'h36
`define FSD_RD_STATE      5'h01

`define FSD_PRIV_BIT      7
`define FSD_SUPER_LO      8'h30
`define FSD_SUPER_HI      8'h7f
`define FSD_PART_HI       4'hc

`endif

// *** verilog/fsd_pkg.sv ***
package fsd_pkg;

	typedef enum logic [2:0] {
		FSD_K_SINGLE,
		FSD_K_DOUBLE,
		FSD_K_STATE,
		FSD_K_BLOCK,
		FSD_K_MASKED,
		FSD_K_SHORT
	} fsd_kind_t;

	typedef enum logic [2:0] {
		FSD_T_NONE,
		FSD_T_BAD_ENCODING,
		FSD_T_FLOAT_OFF,
		FSD_T_SUPERVISOR_ONLY,
		FSD_T_SPACE_REJECT,
		FSD_T_MISALIGN,
		FSD_T_DOUBLE_MISALIGN
	} fsd_trap_t;

	typedef struct packed {
		fsd_kind_t   kind;
		logic [7:0]  space;
		logic [63:0] addr;
		logic [63:0] data;
		logic [4:0]  freg;
	} fsd_mem_req_t;

endpackage : fsd_pkg

// *** verilog/fsd_store_check.sv ***
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "fsd_consts.svh"

// Summary of operation
// - Opcodes 10 0100, 10 0111, 10 0110 decode as single, double, quad.
// - Opcode 10 0101 with destination 1 is state store; 0 and 2 to 31 reserved.
// - Single store writes the 32-bit register named by destination field.
// - Double store writes 64 bits; memory may split it into two words.
// - Quad store is 128 bits architecturally, atomic only per word.
// - State store waits for float operations, writes 64 bits, clears type.
// - Trap type clear happens only once the store is known trap free.
// - Plain stores use implicit space; address is src1 plus src2 or offset.
// - Single, double, state with i zero and bits 12:5 nonzero: bad encoding.
// - Single, double, state trap float off without unit or enables.
// - Single not word aligned, state not doubleword aligned: misalign trap.
// - Double word aligned but not doubleword aligned: double misalign trap.
// - Quad stores raise bad encoding; software emulates them.
// - Opcodes 11 0100, 11 0111, 11 0110 decode as alternate space forms.
// - Alternate space comes from inline code if i zero, else register.
// - Space bit 7 zero in user mode raises supervisor only trap.
// - In supervisor mode spaces 30 to 7f raise supervisor only trap.
// - Single and quad alternate accept only fourteen listed spaces.
// - Double alternate kinds are told apart only by the space code.
// - Double alternate of double kind, word aligned but not doubleword aligned, raises double misalign.
// - Single alternate not word aligned raises misalign trap.
// - Double alternate with block space executes a block store.
module fsd_store_check
	import fsd_pkg::*;
#(
	// Plain-store space codes, big-endian then little-endian pairs.
	parameter logic [8*14-1:0] SPACE_PLAIN = {8'h04, 8'h0c, 8'h10, 8'h18,
		8'h11, 8'h19, 8'h14, 8'h1c, 8'h15, 8'h1d, 8'h80, 8'h88, 8'h81, 8'h89},
	parameter logic [8*9-1:0]  SPACE_BLOCK = {8'h16, 8'h17, 8'h1e, 8'h1f,
		8'hf0, 8'hf1, 8'hf8, 8'hf9, 8'he0},
	parameter logic [8*4-1:0]  SPACE_SHORT = {8'hd0, 8'hd1, 8'hd2, 8'hd3}
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [11:0]  paddr,
	input  wire logic [31:0]  pwdata,
	output var  logic [31:0]  prdata,
	output var  logic         pready,
	output var  logic         pslverr,
	input  wire logic         i_insn_valid,
	output var  logic         o_insn_ready,
	input  wire logic [31:0]  i_insn,
	input  wire logic [63:0]  i_src_one,
	input  wire logic [63:0]  i_src_two,
	input  wire logic [63:0]  i_fp_data,
	input  wire logic [63:0]  i_state_reg,
	input  wire logic         i_float_operation_busy,
	output var  logic         o_mem_valid,
	input  wire logic         i_mem_ready,
	output var  fsd_mem_req_t o_mem_req,
	output var  logic         o_trap_valid,
	output var  fsd_trap_t    o_trap_code,
	output var  logic [2:0]   o_trap_type
);

	typedef enum logic [1:0] {FSD_S_IDLE, FSD_S_WAIT_FP, FSD_S_MEM} fsd_state_t;

	fsd_state_t  state_r;
	logic [3:0]  ctrl_r;
	logic [7:0]  space_r;
	logic [2:0]  trap_type_r;
	fsd_trap_t   last_trap_r;

	logic [1:0]  op;
	logic [5:0]  op3;
	logic [4:0]  rd;
	logic        imm_sel;
	logic [7:0]  space_code;
	logic [63:0] eff_addr;
	logic        accept;
	fsd_kind_t   kind;
	fsd_trap_t   trap;

	function automatic logic in_list14(input logic [8*14-1:0] l,
		input logic [7:0] c);
		logic hit;
		hit = 1'b0;
		for (int k = 0; k < 14; k++) begin
			hit = hit | (l[8*k +: 8] == c);
		end
		return hit;
	endfunction : in_list14

	function automatic logic in_list9(input logic [8*9-1:0] l,
		input logic [7:0] c);
		logic hit;
		hit = 1'b0;
		for (int k = 0; k < 9; k++) begin
			hit = hit | (l[8*k +: 8] == c);
		end
		return hit;
	endfunction : in_list9

	function automatic logic in_list4(input logic [8*4-1:0] l,
		input logic [7:0] c);
		logic hit;
		hit = 1'b0;
		for (int k = 0; k < 4; k++) begin
			hit = hit | (l[8*k +: 8] == c);
		end
		return hit;
	endfunction : in_list4

	assign op         = i_insn[31:30];
	assign rd         = i_insn[29:25];
	assign op3        = i_insn[24:19];
	assign imm_sel    = i_insn[13];
	assign space_code = imm_sel ? space_r : i_insn[12:5];
	assign eff_addr   = i_src_one + (imm_sel ?
		{{51{i_insn[12]}}, i_insn[12:0]} : i_src_two);
	assign o_insn_ready = (state_r == FSD_S_IDLE);
	assign accept       = i_insn_valid && o_insn_ready;

	// Checks are ordered so the first failing class decides the trap.
	always_comb begin
		logic is_alt;
		logic fp_ok;
		logic blk;
		logic part;
		logic shrt;
		is_alt = 1'b0;
		fp_ok  = ctrl_r[`FSD_CTRL_PRESENT] && ctrl_r[`FSD_CTRL_FPEN] &&
			ctrl_r[`FSD_CTRL_STEN];
		blk    = in_list9(SPACE_BLOCK, space_code);
		part   = (space_code[7:4] == `FSD_PART_HI) &&
			(space_code[2:1] != 2'b11);
		shrt   = in_list4(SPACE_SHORT, space_code);
		kind   = FSD_K_SINGLE;
		trap   = FSD_T_NONE;
		if (op != `FSD_OP_MEM) begin
			trap = FSD_T_BAD_ENCODING;
		end else begin
			case (op3)
				`FSD_OP3_SINGLE: kind = FSD_K_SINGLE;
				`FSD_OP3_DOUBLE: kind = FSD_K_DOUBLE;
				`FSD_OP3_STATE: begin
					kind = FSD_K_STATE;
					if (rd != `FSD_RD_STATE) begin
						trap = FSD_T_BAD_ENCODING;
					end
				end
				`FSD_OP3_SINGLE_A: begin
					kind   = FSD_K_SINGLE;
					is_alt = 1'b1;
				end
				`FSD_OP3_DOUBLE_A: begin
					is_alt = 1'b1;
					if (blk) begin
						kind = FSD_K_BLOCK;
					end else if (part) begin
						kind = FSD_K_MASKED;
					end else if (shrt) begin
						kind = FSD_K_SHORT;
					end else begin
						kind = FSD_K_DOUBLE;
					end
				end
				default: trap = FSD_T_BAD_ENCODING;
			endcase
		end
		if (trap == FSD_T_NONE) begin
			if (!is_alt && !imm_sel && (i_insn[12:5] != 8'h00)) begin
				trap = FSD_T_BAD_ENCODING;
			end else if (!fp_ok) begin
				trap = FSD_T_FLOAT_OFF;
			end else if (is_alt && !ctrl_r[`FSD_CTRL_SUPER] &&
				!space_code[`FSD_PRIV_BIT]) begin
				trap = FSD_T_SUPERVISOR_ONLY;
			end else if (is_alt && ctrl_r[`FSD_CTRL_SUPER] &&
				space_code >= `FSD_SUPER_LO &&
				space_code <= `FSD_SUPER_HI) begin
				trap = FSD_T_SUPERVISOR_ONLY;
			end else if (is_alt && !in_list14(SPACE_PLAIN, space_code) &&
				!(op3 == `FSD_OP3_DOUBLE_A && (blk || part || shrt))) begin
				trap = FSD_T_SPACE_REJECT;
			end else if (eff_addr[1:0] != 2'b00 &&
				(kind == FSD_K_SINGLE || kind == FSD_K_DOUBLE)) begin
				trap = FSD_T_MISALIGN;
			end else if (kind == FSD_K_STATE && eff_addr[2:0] != 3'h0) begin
				trap = FSD_T_MISALIGN;
			end else if (kind == FSD_K_BLOCK && eff_addr[5:0] != 6'h00) begin
				trap = FSD_T_MISALIGN;
			end else if (kind == FSD_K_DOUBLE && eff_addr[2]) begin
				trap = FSD_T_DOUBLE_MISALIGN;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_r <= FSD_S_IDLE;
		end else begin
			case (state_r)
				FSD_S_IDLE: begin
					if (accept && trap == FSD_T_NONE) begin
						state_r <= (kind == FSD_K_STATE) ?
							FSD_S_WAIT_FP : FSD_S_MEM;
					end
				end
				FSD_S_WAIT_FP: begin
					if (!i_float_operation_busy) begin
						state_r <= FSD_S_MEM;
					end
				end
				FSD_S_MEM: begin
					if (i_mem_ready) begin
						state_r <= FSD_S_IDLE;
					end
				end
				default: state_r <= FSD_S_IDLE;
			endcase
		end
	end

	// Double and state data go out as one request; the memory side may
	// commit it word by word, as only word atomicity is promised.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_mem_req <= '0;
		end else if (accept && trap == FSD_T_NONE) begin
			o_mem_req.kind  <= kind;
			o_mem_req.space <= space_code;
			o_mem_req.addr  <= eff_addr;
			o_mem_req.freg  <= rd;
			o_mem_req.data  <= (kind == FSD_K_SINGLE) ?
				{32'h0000_0000, i_fp_data[31:0]} : i_fp_data;
		end else if (state_r == FSD_S_WAIT_FP && !i_float_operation_busy) begin
			o_mem_req.data <= i_state_reg;
		end
	end

	assign o_mem_valid = (state_r == FSD_S_MEM);

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_trap_valid <= 1'b0;
			o_trap_code  <= FSD_T_NONE;
			last_trap_r  <= FSD_T_NONE;
		end else begin
			o_trap_valid <= accept && (trap != FSD_T_NONE);
			if (accept) begin
				o_trap_code <= trap;
				last_trap_r <= trap;
			end
		end
	end

	// Clearing only on the memory handshake keeps a trapped store's
	// trap type visible to the handler.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			trap_type_r <= `FSD_TT_RST;
		end else if (state_r == FSD_S_MEM && i_mem_ready &&
			o_mem_req.kind == FSD_K_STATE) begin
			trap_type_r <= `FSD_TT_RST;
		end else if (psel && penable && pwrite &&
			paddr == `FSD_OFF_TRAPTYPE) begin
			trap_type_r <= pwdata[2:0];
		end
	end

	assign o_trap_type = trap_type_r;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ctrl_r  <= `FSD_CTRL_RST;
			space_r <= `FSD_SPACE_RST;
		end else if (psel && penable && pwrite) begin
			if (paddr == `FSD_OFF_CTRL) begin
				ctrl_r <= pwdata[3:0];
			end
			if (paddr == `FSD_OFF_SPACE) begin
				space_r <= pwdata[7:0];
			end
		end
	end

	// Read data is captured in the setup cycle so the access phase
	// answers at once with registered data.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pslverr <= 1'b0;
			case (paddr)
				`FSD_OFF_CTRL:     prdata <= {28'h0, ctrl_r};
				`FSD_OFF_SPACE:    prdata <= {24'h0, space_r};
				`FSD_OFF_STATUS:   prdata <= {26'h0, state_r, 1'b0,
					last_trap_r};
				`FSD_OFF_TRAPTYPE: prdata <= {29'h0, trap_type_r};
				default: begin
					prdata  <= 32'h0000_0000;
					pslverr <= 1'b1;
				end
			endcase
		end
	end

	assign pready = psel && penable;

	sequence s_state_done;
		state_r == FSD_S_MEM && i_mem_ready && o_mem_req.kind == FSD_K_STATE;
	endsequence

	quad_enc_a: assert property (@(posedge i_clk) disable iff (i_rst)
		accept && op == `FSD_OP_MEM && (op3 == `FSD_OP3_QUAD ||
		op3 == `FSD_OP3_QUAD_A) |=> o_trap_valid &&
		o_trap_code == FSD_T_BAD_ENCODING)
		else $error("quad store did not raise bad encoding");

	rsvd_state_a: assert property (@(posedge i_clk) disable iff (i_rst)
		accept && op == `FSD_OP_MEM && op3 == `FSD_OP3_STATE &&
		rd != `FSD_RD_STATE |=> o_trap_code == FSD_T_BAD_ENCODING ##1
		state_r == FSD_S_IDLE)
		else $error("reserved state store not refused");

	fp_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
		accept && !ctrl_r[`FSD_CTRL_FPEN] && trap != FSD_T_BAD_ENCODING
		|=> o_trap_valid && o_trap_code == FSD_T_FLOAT_OFF)
		else $error("float off trap missing");

	state_wait_a: assert property (@(posedge i_clk) disable iff (i_rst)
		state_r == FSD_S_WAIT_FP && i_float_operation_busy |=> !o_mem_valid)
		else $error("state store issued while float ops busy");

	tt_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
		s_state_done |=> o_trap_type == 3'h0)
		else $error("trap type not cleared after state store");

	trap_no_mem_a: assert property (@(posedge i_clk) disable iff (i_rst)
		accept && trap != FSD_T_NONE |=> !o_mem_valid ##1
		(!o_mem_valid || $past(accept)))
		else $error("trapped store reached memory");

	dbl_mis_a: assert property (@(posedge i_clk) disable iff (i_rst)
		accept && trap == FSD_T_NONE && kind == FSD_K_DOUBLE |=>
		o_mem_req.addr[2:0] == 3'h0)
		else $error("double store issued to odd word");

	user_priv_a: assert property (@(posedge i_clk) disable iff (i_rst)
		accept && !ctrl_r[`FSD_CTRL_SUPER] && op == `FSD_OP_MEM &&
		trap == FSD_T_NONE && op3[4] |-> space_code[`FSD_PRIV_BIT])
		else $error("user store to privileged space accepted");

	single_al_a: assert property (@(posedge i_clk) disable iff (i_rst)
		accept && trap == FSD_T_NONE && kind == FSD_K_SINGLE |=>
		o_mem_valid && o_mem_req.addr[1:0] == 2'b00)
		else $error("single store misaligned or not issued");

	sup_range_a: assert property (@(posedge i_clk) disable iff (i_rst)
		accept && trap == FSD_T_NONE && op3[4] && ctrl_r[`FSD_CTRL_SUPER] |->
		!(space_code >= `FSD_SUPER_LO && space_code <= `FSD_SUPER_HI))
		else $error("supervisor store to reserved space accepted");

	space_rej_a: assert property (@(posedge i_clk) disable iff (i_rst)
		accept && trap == FSD_T_NONE && op3 == `FSD_OP3_SINGLE_A |->
		in_list14(SPACE_PLAIN, space_code))
		else $error("single alternate store to unlisted space accepted");

	enc_bits_a: assert property (@(posedge i_clk) disable iff (i_rst)
		accept && trap == FSD_T_NONE && !op3[4] && !imm_sel |->
		i_insn[12:5] == 8'h00)
		else $error("plain store with nonzero reserved bits accepted");

	state_al_a: assert property (@(posedge i_clk) disable iff (i_rst)
		accept && trap == FSD_T_NONE && kind == FSD_K_STATE |->
		eff_addr[2:0] == 3'h0)
		else $error("state store issued to unaligned address");

endmodule : fsd_store_check

`default_nettype wire
